/* src/thermal_fault_and_strap_config.sv */
// thermal source selection, overtemperature shutdown, monitors, straps and calibration start
// assumes synchronous inputs on core_clk and an outside pull-up on the alert pin
`include "thermal_defs.svh"
`default_nettype none
module thermal_fault_and_strap_config
    import thermal_pkg::*;
#(
    parameter int TW = 12,
    parameter int MW = 12,
    parameter int SW = 8
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic en_pin,
    input wire logic signed [TW-1:0] die_temp,
    input wire logic die_temp_valid,
    input wire logic signed [TW-1:0] remote_temp,
    input wire logic remote_temp_valid,
    input wire logic remote_in_range,
    input wire logic remote_junction_sense_grounded,
    input wire logic [MW-1:0] vin_sample,
    input wire logic [MW-1:0] vout_sample,
    input wire logic [MW-1:0] iout_sample,
    input wire logic mon_valid,
    input wire logic [SW-1:0] strap_cfg,
    input wire logic nvm_stored_valid,
    input wire logic [2*TW-1:0] nvm_stored_data,
    output logic nvm_wr,
    output logic [2*TW-1:0] nvm_wr_data,
    output logic cal_start,
    input wire logic cal_done,
    output logic regulation_enable,
    output logic power_good_out,
    output logic signed [TW-1:0] tempco_temp,
    output logic tempco_temp_valid,
    output logic host_attention_request_out,
    output logic host_attention_request_oe_b,
    output logic irq
);
    // ==========================================================
    // declarations
    logic remote_en;
    logic auto_restart;
    logic signed [TW-1:0] fault_limit;
    logic signed [TW-1:0] warn_limit;
    logic [MW-1:0] vin_limit;
    logic [MW-1:0] vout_limit;
    logic [MW-1:0] iout_limit;
    logic [`ST_BITS-1:0] status;
    logic [`ST_BITS-1:0] mask;
    logic [`ST_BITS-1:0] events;
    logic signed [TW-1:0] die_t_q;
    logic signed [TW-1:0] remote_t_q;
    logic [SW-1:0] strap_reg;
    logic strap_taken;
    logic remote_usable;
    logic signed [TW-1:0] sel_temp;
    logic sel_valid;
    logic ot_fault;
    logic ot_fault_d;
    logic [2:0] mon_flag;
    logic [2:0] mon_flag_d;
    logic cal_req;
    logic ctrl_wr;
    pstate_t state;
    pstate_t next_state;
    logic [MW-1:0] mon_sample [3];
    logic [MW-1:0] mon_limit [3];

    assign ctrl_wr = reg_wr && reg_addr == `REG_CTRL;

    // ==========================================================
    // temperature source selection
    // grounded sense disables
    assign remote_usable = remote_en && !remote_junction_sense_grounded && remote_in_range;
    assign sel_temp = remote_usable ? remote_temp : die_temp;
    assign sel_valid = remote_usable ? remote_temp_valid : die_temp_valid;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            die_t_q <= '0;
            remote_t_q <= '0;
        end else begin
            if (die_temp_valid) begin
                die_t_q <= die_temp;
            end
            // a remote sensor with grounded sense keeps its last value for readback
            if (remote_temp_valid && !remote_junction_sense_grounded) begin
                remote_t_q <= remote_temp;
            end
        end
    end

    // current compensation follows the same source as fault protection
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tempco_temp <= '0;
            tempco_temp_valid <= 1'b0;
        end else begin
            tempco_temp_valid <= sel_valid;
            if (sel_valid) begin
                tempco_temp <= sel_temp;
            end
        end
    end

    // ==========================================================
    // overtemperature with warning-level hysteresis
    // fault hysteresis
    hyst_compare #(.W(TW)) u_ot (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sample(sel_temp),
        .sample_valid(sel_valid),
        .set_level(fault_limit),
        .clr_level(warn_limit),
        .flag(ot_fault)
    );

    // ==========================================================
    // voltage and current monitors
    assign mon_sample[0] = vin_sample;
    assign mon_sample[1] = vout_sample;
    assign mon_sample[2] = iout_sample;
    assign mon_limit[0] = vin_limit;
    assign mon_limit[1] = vout_limit;
    assign mon_limit[2] = iout_limit;

    for (genvar i = 0; i < 3; i++) begin : g_mon
        hyst_compare #(.W(MW + 1)) u_mon (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .sample({1'b0, mon_sample[i]}),
            .sample_valid(mon_valid),
            .set_level({1'b0, mon_limit[i]}),
            .clr_level({1'b0, mon_limit[i]}),
            .flag(mon_flag[i])
        );
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ot_fault_d <= 1'b0;
            mon_flag_d <= '0;
        end else begin
            ot_fault_d <= ot_fault;
            mon_flag_d <= mon_flag;
        end
    end

    always_comb begin
        events = '0;
        events[`ST_OT_FAULT] = ot_fault && !ot_fault_d;
        events[`ST_OT_CLEAR] = !ot_fault && ot_fault_d;
        events[`ST_VIN] = mon_flag[0] && !mon_flag_d[0];
        events[`ST_VOUT] = mon_flag[1] && !mon_flag_d[1];
        events[`ST_IOUT] = mon_flag[2] && !mon_flag_d[2];
        events[`ST_CAL_DONE] = state == PS_CAL && cal_done;
    end

    // ==========================================================
    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else if (reg_wr && reg_addr == `REG_STATUS) begin
            status <= (status & ~reg_wdata[`ST_BITS-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    assign irq = |(status & mask);
    assign host_attention_request_out = 1'b0;
    assign host_attention_request_oe_b = !irq;

    // ==========================================================
    // one-shot strap and stored configuration capture
    // sample once
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_taken <= 1'b0;
            strap_reg <= '0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            strap_reg <= strap_cfg;
        end
    end

    // ==========================================================
    // host configuration registers
    // programmable limits
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_limit <= `FAULT_LIM_RESET;
            warn_limit <= `WARN_LIM_RESET;
        end else if (!strap_taken && nvm_stored_valid) begin
            fault_limit <= nvm_stored_data[TW-1:0];
            warn_limit <= nvm_stored_data[2*TW-1:TW];
        end else if (reg_wr) begin
            if (reg_addr == `REG_FAULT_LIM) begin
                fault_limit <= reg_wdata[TW-1:0];
            end
            if (reg_addr == `REG_WARN_LIM) begin
                warn_limit <= reg_wdata[TW-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            vin_limit <= `MON_LIM_RESET;
            vout_limit <= `MON_LIM_RESET;
            iout_limit <= `MON_LIM_RESET;
            mask <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `REG_VIN_LIM) begin
                vin_limit <= reg_wdata[MW-1:0];
            end
            if (reg_addr == `REG_VOUT_LIM) begin
                vout_limit <= reg_wdata[MW-1:0];
            end
            if (reg_addr == `REG_IOUT_LIM) begin
                iout_limit <= reg_wdata[MW-1:0];
            end
            if (reg_addr == `REG_MASK) begin
                mask <= reg_wdata[`ST_BITS-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {auto_restart, remote_en} <= `CTRL_RESET;
        end else if (ctrl_wr) begin
            remote_en <= reg_wdata[`CTRL_REMOTE_EN];
            auto_restart <= reg_wdata[`CTRL_AUTO_RESTART];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            nvm_wr <= 1'b0;
            nvm_wr_data <= '0;
        end else begin
            nvm_wr <= ctrl_wr && reg_wdata[`CTRL_NVM_COMMIT];
            if (ctrl_wr && reg_wdata[`CTRL_NVM_COMMIT]) begin
                nvm_wr_data <= {warn_limit, fault_limit};
            end
        end
    end

    // ==========================================================
    // power sequencing
    // a host calibration request is held until the sequencer can act on it
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_req <= 1'b0;
        end else if (ctrl_wr && reg_wdata[`CTRL_CAL_CMD]) begin
            cal_req <= 1'b1;
        end else if (state == PS_CAL) begin
            cal_req <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            PS_IDLE: begin
                if (ot_fault) begin
                    next_state = PS_FAULT;
                end else if (en_pin && strap_taken) begin
                    next_state = PS_CAL;
                end
            end
            PS_CAL: begin
                if (ot_fault) begin
                    next_state = PS_FAULT;
                end else if (!en_pin) begin
                    next_state = PS_IDLE;
                end else if (cal_done) begin
                    next_state = PS_RUN;
                end
            end
            PS_RUN: begin
                if (ot_fault) begin
                    next_state = PS_FAULT;
                end else if (!en_pin) begin
                    next_state = PS_IDLE;
                end else if (cal_req) begin
                    next_state = PS_CAL;
                end
            end
            PS_FAULT: begin
                if (!ot_fault && (auto_restart || !en_pin)) begin
                    next_state = PS_IDLE;
                end
            end
            default: begin
                next_state = PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= PS_IDLE;
            cal_start <= 1'b0;
        end else begin
            state <= next_state;
            cal_start <= next_state == PS_CAL && state != PS_CAL;
        end
    end

    assign regulation_enable = state == PS_CAL || state == PS_RUN;
    assign power_good_out = state == PS_RUN;

    // ==========================================================
    // register readback, one cycle after the read strobe
    // temperature reads
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL: reg_rdata <= 16'({auto_restart, remote_en});
                `REG_FAULT_LIM: reg_rdata <= 16'(fault_limit);
                `REG_WARN_LIM: reg_rdata <= 16'(warn_limit);
                `REG_TEMP1: reg_rdata <= 16'(die_t_q);
                `REG_TEMP2: reg_rdata <= 16'(remote_t_q);
                `REG_TEMP_SEL: reg_rdata <= {remote_usable, 15'(sel_temp)};
                `REG_STATUS: reg_rdata <= 16'(status);
                `REG_MASK: reg_rdata <= 16'(mask);
                `REG_VIN_LIM: reg_rdata <= 16'(vin_limit);
                `REG_VOUT_LIM: reg_rdata <= 16'(vout_limit);
                `REG_IOUT_LIM: reg_rdata <= 16'(iout_limit);
                `REG_STRAP: reg_rdata <= 16'(strap_reg);
                `REG_PSTATE: reg_rdata <= 16'({ot_fault, power_good_out, regulation_enable, state});
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_TEMP1_READ: assert property (reg_rd && reg_addr == `REG_TEMP1 |=>
        reg_rdata == 16'($past(die_t_q))) else $error("die temperature readback wrong");
    AST_DIE_FALLBACK: assert property (!remote_usable && die_temp_valid |=>
        tempco_temp == $past(die_temp) && tempco_temp_valid) else $error("no die fallback");
    AST_REMOTE_USED: assert property (remote_usable && remote_temp_valid |=>
        tempco_temp == $past(remote_temp)) else $error("remote source not used");
    AST_GROUND_OFF: assert property (remote_junction_sense_grounded |->
        !remote_usable && sel_valid == die_temp_valid) else $error("grounded sense not off");
    AST_FAULT_SET: assert property (sel_valid && sel_temp >= fault_limit |=>
        ot_fault) else $error("fault not raised at limit");
    AST_FAULT_HOLD: assert property (ot_fault && !(sel_valid && sel_temp < warn_limit) |=>
        ot_fault) else $error("fault cleared above warning limit");
    AST_RESTART: assert property (state == PS_FAULT && !ot_fault && auto_restart |=>
        state == PS_IDLE) else $error("no restart after fault cleared");
    AST_SHUTDOWN: assert property (ot_fault |=>
        !regulation_enable && !power_good_out) else $error("regulating during fault");
    AST_STATUS_READ: assert property (reg_rd && reg_addr == `REG_PSTATE |=>
        reg_rdata[3:0] == $past(state)) else $error("state readback wrong");
    AST_STRAP_ONCE: assert property (strap_taken |=>
        $stable(strap_reg) && strap_taken) else $error("strap changed after capture");
    AST_COMMIT: assert property (ctrl_wr && reg_wdata[`CTRL_NVM_COMMIT] |=>
        nvm_wr && nvm_wr_data == $past({warn_limit, fault_limit})) else $error("commit lost");
    AST_CAL_ON_ENABLE: assert property (state == PS_IDLE && en_pin && strap_taken
        && !ot_fault |=> cal_start && state == PS_CAL) else $error("no calibration on enable");
    AST_ALERT_PIN: assert property (host_attention_request_oe_b == !(|(status & mask))
        && !host_attention_request_out) else $error("alert pin mismatch");

    COV_FAULT: cover property (state == PS_RUN ##1 state == PS_FAULT);
    COV_RESTART: cover property (state == PS_FAULT ##1 state == PS_IDLE ##1 state == PS_CAL);
    COV_CAL_RUN: cover property (state == PS_CAL ##1 state == PS_RUN);
    COV_ALERT: cover property ($fell(host_attention_request_oe_b));
endmodule
`default_nettype wire

/* src/thermal_defs.svh */
// constants for the thermal fault and strap configuration block
// assumes one 20 MHz core clock and a plain single-cycle register port
//
// Contract
// - a read of the first temperature register returns the die temperature and a read of the second returns the remote temperature.
// - with the remote sensor disabled or out of range, the die temperature drives fault checks and current compensation.
// - with a valid remote junction attached, the remote temperature drives fault checks and current compensation.
// - a remote sense input held at ground disables remote measurement entirely.
// - fault and warning thresholds are host programmable and the fault threshold resets to 115 degrees.
// - the fault rises when the temperature reaches the fault threshold and clears only below the warning threshold.
// - by default a fault shuts the output down and the block restarts by itself once the fault clears.
// - while acting on a temperature fault, regulation is off and power good is low.
// - input voltage, output voltage, current and the selected temperature are watched and alert on host-set limits.
// - power-supply status can be read at any time, also while regulating or in fault.
// - the strap configuration is sampled once after power-up and later changes are ignored.
// - host fault and warning thresholds can be committed to nonvolatile storage and are used at the next power-up.
// - calibration starts whenever the output is enabled or the host asks for it.
// - the open-drain alert pin is pulled low while the host must service the block, released otherwise.
`ifndef THERMAL_DEFS_SVH
`define THERMAL_DEFS_SVH

// ==========================================================
// register offsets
`define REG_CTRL 8'h00
`define REG_FAULT_LIM 8'h04
`define REG_WARN_LIM 8'h08
`define REG_TEMP1 8'h0C
`define REG_TEMP2 8'h10
`define REG_TEMP_SEL 8'h14
`define REG_STATUS 8'h18
`define REG_MASK 8'h1C
`define REG_VIN_LIM 8'h20
`define REG_VOUT_LIM 8'h24
`define REG_IOUT_LIM 8'h28
`define REG_STRAP 8'h2C
`define REG_PSTATE 8'h30

// ==========================================================
// control fields and reset values
`define CTRL_REMOTE_EN 0
`define CTRL_AUTO_RESTART 1
`define CTRL_CAL_CMD 2
`define CTRL_NVM_COMMIT 3
`define CTRL_RESET 2'h3
`define FAULT_LIM_RESET 12'h073
`define WARN_LIM_RESET 12'h069
`define MON_LIM_RESET 12'hFFF

// ==========================================================
// status bits
`define ST_OT_FAULT 0
`define ST_OT_CLEAR 1
`define ST_VIN 2
`define ST_VOUT 3
`define ST_IOUT 4
`define ST_CAL_DONE 5
`define ST_BITS 6

`endif

/* src/thermal_pkg.sv */
// types shared by the thermal fault block
// assumes nothing beyond the synthesis tool
`default_nettype none
package thermal_pkg;
    // ==========================================================
    // power sequencing states
    typedef enum logic [3:0] {
        PS_IDLE = 4'b0001,
        PS_CAL = 4'b0010,
        PS_RUN = 4'b0100,
        PS_FAULT = 4'b1000
    } pstate_t;
endpackage
`default_nettype wire

/* src/hyst_compare.sv */
// hysteresis comparator: sets at or above one level, clears below another
// assumes samples arrive with a one-cycle valid strobe
`default_nettype none
module hyst_compare #(
    parameter int W = 12
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic signed [W-1:0] sample,
    input wire logic sample_valid,
    input wire logic signed [W-1:0] set_level,
    input wire logic signed [W-1:0] clr_level,
    output logic flag
);
    // ==========================================================
    // flag with hysteresis
    // set and clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (sample_valid) begin
            if (!flag && sample >= set_level) begin
                flag <= 1'b1;
            end else if (flag && sample < clr_level) begin
                flag <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/host_model.sv */
// host model for the register port: single-cycle reads and writes
// assumes the slave answers a read in the cycle after the strobe
`default_nettype none
module host_model (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // bus cycles
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // released lines move so a stale value is never trusted
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
    task automatic limits(input logic [15:0] f, input logic [15:0] w);
        wr(8'h08, w);
        wr(8'h04, f);
    endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// bench for the thermal fault and strap block
// assumes host_model on the register port; sensors driven here
`include "thermal_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, rst_b = 1'b0, en_pin = 1'b0, cal_done = 1'b0;
    logic die_temp_valid = 1'b0, remote_temp_valid = 1'b0, mon_valid = 1'b0;
    logic remote_in_range = 1'b1, remote_junction_sense_grounded = 1'b0;
    logic signed [11:0] die_temp = 12'h000, remote_temp = 12'h000, tempco_temp;
    logic [11:0] mon [3] = '{12'h000, 12'h000, 12'h000};
    logic [7:0] strap_cfg = 8'hA5, reg_addr;
    logic nvm_stored_valid = 1'b0, reg_wr, reg_rd, nvm_wr, cal_start, irq;
    logic [23:0] nvm_stored_data = 24'h000000, nvm_wr_data;
    logic [15:0] reg_wdata, reg_rdata, rdat;
    logic regulation_enable, power_good_out, tempco_temp_valid, oe_b, attn_out;
    int errors = 0;
    int tests_run = 0;
    host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    thermal_fault_and_strap_config u_dut (.core_clk(core_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .en_pin(en_pin), .die_temp(die_temp),
        .die_temp_valid(die_temp_valid), .remote_temp(remote_temp),
        .remote_temp_valid(remote_temp_valid), .remote_in_range(remote_in_range),
        .remote_junction_sense_grounded(remote_junction_sense_grounded),
        .vin_sample(mon[0]), .vout_sample(mon[1]), .iout_sample(mon[2]),
        .mon_valid(mon_valid), .strap_cfg(strap_cfg), .nvm_stored_valid(nvm_stored_valid),
        .nvm_stored_data(nvm_stored_data), .nvm_wr(nvm_wr), .nvm_wr_data(nvm_wr_data),
        .cal_start(cal_start), .cal_done(cal_done), .regulation_enable(regulation_enable),
        .power_good_out(power_good_out), .tempco_temp(tempco_temp),
        .tempco_temp_valid(tempco_temp_valid), .host_attention_request_out(attn_out),
        .host_attention_request_oe_b(oe_b), .irq(irq));
    // ==========================================================
    // helpers
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
        u_host.rd(a, rdat);
        chk(n, 24'(rdat), 24'(e));
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    // one sample pulse, then wait for the fault state to land
    task automatic samp(input logic rem, input logic signed [11:0] t);
        @(posedge core_clk);
        if (rem) begin
            remote_temp <= t;
            remote_temp_valid <= 1'b1;
        end else begin
            die_temp <= t;
            die_temp_valid <= 1'b1;
        end
        @(posedge core_clk);
        remote_temp_valid <= 1'b0;
        die_temp_valid <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic wait_hi(input string n, input bit nvm);
        int k;
        // look once before the first edge: a pulse launched by the caller's last edge counts
        for (k = 0; k < 40; k++) begin
            #1;
            if ((nvm ? nvm_wr : cal_start) === 1'b1) break;
            @(posedge core_clk);
        end
        chk(n, 24'(k < 40), 24'h000001);
        if (k == 40) end_of_test();
    endtask
    task automatic cal_finish;
        @(posedge core_clk);
        cal_done <= 1'b1;
        @(posedge core_clk);
        cal_done <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("pg_run", 24'(power_good_out), 24'h000001);
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        chk("pg_rst", 24'(power_good_out), 24'h000000);
        rchk("fault_lim", `REG_FAULT_LIM, 16'h0073);
        rchk("ctrl", `REG_CTRL, 16'h0003);
        rchk("unmapped", 8'hFC, 16'h0000);
        @(posedge core_clk);
        strap_cfg <= 8'h5A;
        en_pin <= 1'b1;
        wait_hi("cal_enable", 1'b0);
        rchk("strap", `REG_STRAP, 16'h00A5);
        cal_finish();
        rchk("pstate_run", `REG_PSTATE, 16'h0034);
        samp(1'b0, 12'sd25);
        samp(1'b1, 12'sd40);
        chk("tempco_rem", 24'(tempco_temp), 24'h000028);
        rchk("temp1", `REG_TEMP1, 16'h0019);
        rchk("temp2", `REG_TEMP2, 16'h0028);
        done("startup");
        u_host.wr(`REG_STATUS, 16'h003F);
        u_host.wr(`REG_MASK, 16'h0001);
        samp(1'b1, 12'sd115);
        chk("reg_en_flt", 24'(regulation_enable), 24'h000000);
        chk("pg_flt", 24'(power_good_out), 24'h000000);
        chk("alert_low", 24'(oe_b), 24'h000000);
        chk("alert_drive", 24'(attn_out), 24'h000000);
        samp(1'b1, 12'sd105);
        rchk("pstate_hold", `REG_PSTATE, 16'h0048);
        samp(1'b1, 12'sd104);
        wait_hi("restart", 1'b0);
        cal_finish();
        rchk("status", `REG_STATUS, 16'h0023);
        u_host.wr(`REG_STATUS, 16'h0023);
        rchk("status_clr", `REG_STATUS, 16'h0000);
        chk("alert_off", 24'(oe_b), 24'h000001);
        done("remote_fault");
        u_host.limits(16'h003C, 16'h0032);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            remote_junction_sense_grounded <= (k == 0);
            remote_in_range <= (k == 0);
            samp(1'b1, 12'sd70);
            rchk("rem_ignored", `REG_PSTATE, 16'h0034);
            samp(1'b0, 12'sd60);
            chk("tempco_die", 24'(tempco_temp), 24'h00003C);
            rchk("die_fault", `REG_PSTATE, 16'h0048);
            samp(1'b0, 12'sd50);
            rchk("die_hold", `REG_PSTATE, 16'h0048);
            samp(1'b0, 12'sd49);
            wait_hi("die_restart", 1'b0);
            cal_finish();
        end
        u_host.wr(`REG_CTRL, 16'h0007);
        wait_hi("cal_cmd", 1'b0);
        cal_finish();
        done("fallback");
        u_host.wr(`REG_STATUS, 16'h003F);
        u_host.wr(`REG_MASK, 16'h001C);
        for (int i = 0; i < 3; i++) begin
            u_host.wr(8'(`REG_VIN_LIM + 4 * i), 16'h0064);
            mon[i] <= 12'h064;
            @(posedge core_clk);
            mon_valid <= 1'b1;
            @(posedge core_clk);
            mon_valid <= 1'b0;
            rchk("mon_status", `REG_STATUS, 16'(1 << (2 + i)));
            chk("irq_mon", 24'(irq), 24'h000001);
            u_host.wr(`REG_STATUS, 16'h001C);
            mon[i] <= 12'h000;
        end
        done("monitors");
        u_host.wr(`REG_CTRL, 16'h000B);
        wait_hi("nvm_pulse", 1'b1);
        chk("nvm_data", nvm_wr_data, 24'h03203C);
        @(posedge core_clk);
        nvm_stored_data <= 24'h03203C;
        nvm_stored_valid <= 1'b1;
        do_reset();
        rchk("nvm_fault", `REG_FAULT_LIM, 16'h003C);
        rchk("nvm_warn", `REG_WARN_LIM, 16'h0032);
        done("nvm");
        end_of_test();
    end
endmodule
`default_nettype wire
